// [verilog/aord_pkg.sv]
package aord_pkg;
   // register byte offsets on the apb slave
   localparam logic [7:0] AORD_CTRL_OFF = 8'h00;
   localparam logic [7:0] AORD_HIGH_THR_OFF = 8'h04;
   localparam logic [7:0] AORD_LOW_THR_OFF = 8'h08;
   localparam logic [7:0] AORD_FLAGS_OFF = 8'h0C;
   localparam logic [7:0] AORD_INT_STATUS_OFF = 8'h10;
   localparam logic [7:0] AORD_INT_MASK_OFF = 8'h14;

   // control register field positions
   localparam int AORD_CTRL_ENABLE_BIT = 0;
   localparam int AORD_CTRL_SINGLE_BIT = 1;
   localparam int AORD_CTRL_PLS_LSB = 2;
   localparam int AORD_PLS_W = 3;

   // flag bit order in flags, status and mask registers
   localparam int AORD_FLAG_A_HIGH = 0;
   localparam int AORD_FLAG_A_LOW = 1;
   localparam int AORD_FLAG_B_HIGH = 2;
   localparam int AORD_FLAG_B_LOW = 3;
   localparam int AORD_NUM_FLAGS = 4;

   // reset values
   localparam logic AORD_ENABLE_RST = 1'b0;
   localparam logic AORD_SINGLE_RST = 1'b0;
   localparam logic [AORD_PLS_W-1:0] AORD_PLS_RST = 3'h0;
   localparam logic [3:0] AORD_MASK_RST = 4'h0;

   // stretch length is base shifted left by the select, 8 to 1024 cycles
   localparam logic [10:0] AORD_PULSE_BASE = 11'h008;
   localparam int AORD_CNT_W = 11;
endpackage : aord_pkg

// [verilog/aord_stretch.sv]
module aord_stretch
   import aord_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic hit,
   input wire logic [AORD_PLS_W-1:0] pulse_length_sel,
   output logic flag
);

   typedef struct packed {
      logic [AORD_CNT_W-1:0] cnt;
      logic flag;
   } aord_str_type;

   aord_str_type s_q;
   aord_str_type s_d;

   // number of cycles the flag stays up after the last hit
   function automatic logic [AORD_CNT_W-1:0] aord_len(input logic [AORD_PLS_W-1:0] sel);
      aord_len = AORD_PULSE_BASE << sel;
   endfunction : aord_len

   // reload on each hit, count down otherwise; flag falls when the count is spent
   always_comb begin
      s_d = s_q;
      if (hit) begin
         s_d.cnt = aord_len(pulse_length_sel) - 11'h001;
         s_d.flag = 1'b1;
      end else if (s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - 11'h001;
         s_d.flag = 1'b1;
      end else begin
         s_d.flag = 1'b0;
      end
   end

   // clock enable low freezes the counter and the flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign flag = s_q.flag;

endmodule : aord_stretch

// [verilog/aord_detector.sv]
// The APB slave port and the register offsets were chosen for this implementation.
module aord_detector
   import aord_pkg::*;
#(
   parameter int SAMPLE_W = 12
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [SAMPLE_W-1:0] sample_a,
   input wire logic sample_a_valid,
   input wire logic [SAMPLE_W-1:0] sample_b,
   input wire logic sample_b_valid,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chan_a_high_flag,
   output logic chan_a_low_flag,
   output logic chan_b_high_flag,
   output logic chan_b_low_flag,
   output logic irq
);

   localparam int MAG_W = SAMPLE_W - 1;

   ////////////////////////////////////////////////////////////////////////////////
   // parameter check

   generate
      if (SAMPLE_W < 4 || SAMPLE_W > 17) begin : g_bad_width
         $error("aord_detector: SAMPLE_W must lie between 4 and 17");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic enable;
      logic single_mode;
      logic [AORD_PLS_W-1:0] pulse_length_sel;
      logic [MAG_W-1:0] high_threshold;
      logic [MAG_W-1:0] low_threshold;
      logic [AORD_NUM_FLAGS-1:0] int_status;
      logic [AORD_NUM_FLAGS-1:0] int_mask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
   } aord_regs_type;

   aord_regs_type r_q;
   aord_regs_type r_d;

   logic [AORD_NUM_FLAGS-1:0] hit;
   logic [AORD_NUM_FLAGS-1:0] flags;
   logic [MAG_W-1:0] mag_a;
   logic [MAG_W-1:0] mag_b;
   logic setup_phase;
   logic write_taken;

   ////////////////////////////////////////////////////////////////////////////////
   // magnitude and comparison

   // two's-complement to magnitude; the most negative code has no positive twin so it saturates
   function automatic logic [MAG_W-1:0] aord_mag(input logic [SAMPLE_W-1:0] s);
      logic [SAMPLE_W-1:0] neg;
      neg = '0;
      if (!s[SAMPLE_W-1]) begin
         aord_mag = s[MAG_W-1:0];
      end else if (s[MAG_W-1:0] == '0) begin
         aord_mag = '1;
      end else begin
         neg = (~s) + 1'b1;
         aord_mag = neg[MAG_W-1:0];
      end
   endfunction : aord_mag

   // word read back for a register offset; unmapped offsets give zero
   function automatic logic [31:0] aord_read(input logic [7:0] addr, input aord_regs_type r,
                                             input logic [AORD_NUM_FLAGS-1:0] f);
      aord_read = '0;
      unique case (addr)
         AORD_CTRL_OFF: begin
            aord_read[AORD_CTRL_ENABLE_BIT] = r.enable;
            aord_read[AORD_CTRL_SINGLE_BIT] = r.single_mode;
            aord_read[AORD_CTRL_PLS_LSB +: AORD_PLS_W] = r.pulse_length_sel;
         end
         AORD_HIGH_THR_OFF: aord_read[MAG_W-1:0] = r.high_threshold;
         AORD_LOW_THR_OFF: aord_read[MAG_W-1:0] = r.low_threshold;
         AORD_FLAGS_OFF: aord_read[AORD_NUM_FLAGS-1:0] = f;
         AORD_INT_STATUS_OFF: aord_read[AORD_NUM_FLAGS-1:0] = r.int_status;
         AORD_INT_MASK_OFF: aord_read[AORD_NUM_FLAGS-1:0] = r.int_mask;
         default: aord_read = '0;
      endcase
   endfunction : aord_read

   function automatic logic aord_mapped(input logic [7:0] addr);
      aord_mapped = (addr == AORD_CTRL_OFF) || (addr == AORD_HIGH_THR_OFF) ||
                    (addr == AORD_LOW_THR_OFF) || (addr == AORD_FLAGS_OFF) ||
                    (addr == AORD_INT_STATUS_OFF) || (addr == AORD_INT_MASK_OFF);
   endfunction : aord_mapped

   // in single mode sample_a is the rising-edge core and sample_b the falling-edge core,
   // so two samples per clock arrive either way and the comparison path is the same
   assign mag_a = aord_mag(sample_a);
   assign mag_b = aord_mag(sample_b);

   // one threshold pair serves both inputs
   always_comb begin
      hit = '0;
      if (r_q.enable && sample_a_valid) begin
         hit[AORD_FLAG_A_HIGH] = (mag_a >= r_q.high_threshold);
         hit[AORD_FLAG_A_LOW] = (mag_a >= r_q.low_threshold);
      end
      if (r_q.enable && sample_b_valid) begin
         hit[AORD_FLAG_B_HIGH] = (mag_b >= r_q.high_threshold);
         hit[AORD_FLAG_B_LOW] = (mag_b >= r_q.low_threshold);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // stretchers, one per pin; pin order follows the flag bit order

   generate
      for (genvar i = 0; i < AORD_NUM_FLAGS; i++) begin : g_str
         aord_stretch u_str (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .hit(hit[i]),
            .pulse_length_sel(r_q.pulse_length_sel),
            .flag(flags[i])
         );
      end
   endgenerate

   // even-index pins carry the high threshold, odd-index pins the low one
   assign chan_a_high_flag = flags[AORD_FLAG_A_HIGH];
   assign chan_a_low_flag = flags[AORD_FLAG_A_LOW];
   assign chan_b_high_flag = flags[AORD_FLAG_B_HIGH];
   assign chan_b_low_flag = flags[AORD_FLAG_B_LOW];

   ////////////////////////////////////////////////////////////////////////////////
   // apb slave and interrupt logic

   // decoding in the setup cycle keeps prdata and pready on flops with no wait state
   assign setup_phase = psel && !penable && !r_q.pready;
   assign write_taken = psel && penable && r_q.pready && pwrite;

   always_comb begin
      r_d = r_q;
      r_d.pready = 1'b0;
      if (setup_phase) begin
         r_d.pready = 1'b1;
         r_d.pslverr = !aord_mapped(paddr);
         r_d.prdata = pwrite ? 32'h0000_0000 : aord_read(paddr, r_q, flags);
      end else if (psel && penable && r_q.pready) begin
         r_d.pslverr = 1'b0;
         r_d.prdata = '0;
      end
      if (write_taken) begin
         unique case (paddr)
            AORD_CTRL_OFF: begin
               r_d.enable = pwdata[AORD_CTRL_ENABLE_BIT];
               r_d.single_mode = pwdata[AORD_CTRL_SINGLE_BIT];
               r_d.pulse_length_sel = pwdata[AORD_CTRL_PLS_LSB +: AORD_PLS_W];
            end
            AORD_HIGH_THR_OFF: r_d.high_threshold = pwdata[MAG_W-1:0];
            AORD_LOW_THR_OFF: r_d.low_threshold = pwdata[MAG_W-1:0];
            AORD_INT_STATUS_OFF: r_d.int_status = r_q.int_status & ~pwdata[AORD_NUM_FLAGS-1:0];
            AORD_INT_MASK_OFF: r_d.int_mask = pwdata[AORD_NUM_FLAGS-1:0];
            default: r_d.enable = r_q.enable;
         endcase
      end
      // a hit in the cycle of a clearing write still sets its bit
      r_d.int_status = r_d.int_status | hit;
      r_d.irq = |(r_d.int_status & r_d.int_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q <= '{enable: AORD_ENABLE_RST, single_mode: AORD_SINGLE_RST,
                  pulse_length_sel: AORD_PLS_RST, high_threshold: '1, low_threshold: '1,
                  int_status: '0, int_mask: AORD_MASK_RST, prdata: '0,
                  pready: 1'b0, pslverr: 1'b0, irq: 1'b0};
      end else if (ce) begin
         r_q <= r_d;
      end
   end

   assign prdata = r_q.prdata;
   assign pready = r_q.pready;
   assign pslverr = r_q.pslverr;
   assign irq = r_q.irq;

endmodule : aord_detector

// [test/aord_checker.sv]
module aord_checker
   import aord_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic sample_a_valid,
   input wire logic sample_b_valid,
   input wire logic chan_a_high_flag,
   input wire logic chan_a_low_flag,
   input wire logic chan_b_high_flag,
   input wire logic chan_b_low_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] cnt_q;
   // cycles since the last sample on either channel, saturating so it never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 11'h000;
      end else if (ce) begin
         cnt_q <= (sample_a_valid || sample_b_valid) ? 11'h000 : cnt_q + {10'h000, cnt_q != 11'h7FF};
      end
   end
   //////////////////////////////////////////
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_held(f);
      f [*8];
   endsequence
   // a pin may only rise on the edge that took a sample of its own channel
   property p_a_high_cause; $rose(chan_a_high_flag) |-> $past(ce && sample_a_valid); endproperty
   a_a_high_cause: assert property (p_a_high_cause) else $error("a high pin rose with no a sample");
   property p_a_low_cause; $rose(chan_a_low_flag) |-> $past(ce && sample_a_valid); endproperty
   a_a_low_cause: assert property (p_a_low_cause) else $error("a low pin rose with no a sample");
   property p_b_high_cause; $rose(chan_b_high_flag) |-> $past(ce && sample_b_valid); endproperty
   a_b_high_cause: assert property (p_b_high_cause) else $error("b high pin rose with no b sample");
   property p_b_low_cause; $rose(chan_b_low_flag) |-> $past(ce && sample_b_valid); endproperty
   a_b_low_cause: assert property (p_b_low_cause) else $error("b low pin rose with no b sample");
   // the shortest stretch is eight cycles
   property p_a_min; $rose(chan_a_high_flag) |-> s_held(chan_a_high_flag); endproperty
   a_a_min: assert property (p_a_min) else $error("a high pulse under eight cycles");
   property p_b_min; $rose(chan_b_low_flag) |-> s_held(chan_b_low_flag); endproperty
   a_b_min: assert property (p_b_min) else $error("b low pulse under eight cycles");
   // no pin outlives the longest stretch of 1024 cycles
   property p_a_max; (chan_a_high_flag || chan_a_low_flag) |-> cnt_q < 11'h400; endproperty
   a_a_max: assert property (p_a_max) else $error("a pin held past 1024 cycles");
   property p_b_max; (chan_b_high_flag || chan_b_low_flag) |-> cnt_q < 11'h400; endproperty
   a_b_max: assert property (p_b_max) else $error("b pin held past 1024 cycles");
endmodule : aord_checker

bind aord_detector aord_checker aord_checker_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
   .sample_a_valid(sample_a_valid), .sample_b_valid(sample_b_valid), .chan_a_high_flag(chan_a_high_flag),
   .chan_a_low_flag(chan_a_low_flag), .chan_b_high_flag(chan_b_high_flag), .chan_b_low_flag(chan_b_low_flag));

// [test/aord_gain_model.sv]
module aord_gain_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic single,
   input wire logic chan_a_high_flag,
   input wire logic chan_a_low_flag,
   input wire logic chan_b_high_flag,
   input wire logic chan_b_low_flag,
   output logic gain_down,
   output logic gain_up
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] quiet_q;
   // in single mode the two core pins of a threshold are joined
   assign gain_down = chan_a_high_flag | (single & chan_b_high_flag);
   // gain goes up only after the low pin stayed quiet a long while
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_q <= 8'h00;
      end else if (chan_a_low_flag | (single & chan_b_low_flag)) begin
         quiet_q <= 8'h00;
      end else if (quiet_q != 8'hFF) begin
         quiet_q <= quiet_q + 8'h01;
      end
   end
   assign gain_up = (quiet_q == 8'hFF);
endmodule : aord_gain_model

// [test/tb_top.sv]
`define CHK(n, e, g) check_count++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end
module tb_top;
   import aord_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, ce = 1, va = 0, vb = 0, psel = 0, penable = 0, pwrite = 0, single = 0;
   logic [11:0] sa = 0, sb = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic pready, pslverr, fah, fal, fbh, fbl, irq, gdown;
   logic [32:0] q[$];
   logic [32:0] e;
   int n_mismatch = 0, check_count = 0, seed = 32'h0936D000, len;
   int sels[4] = '{0, 1, 2, 7};
   always #5 pclk = ~pclk;
   aord_detector aord_detector_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .sample_a(sa), .sample_a_valid(va),
      .sample_b(sb), .sample_b_valid(vb), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_a_high_flag(fah),
      .chan_a_low_flag(fal), .chan_b_high_flag(fbh), .chan_b_low_flag(fbl), .irq(irq));
   aord_gain_model aord_gain_model_inst (.pclk(pclk), .presetn(presetn), .single(single), .chan_a_high_flag(fah),
      .chan_a_low_flag(fal), .chan_b_high_flag(fbh), .chan_b_low_flag(fbl), .gain_down(gdown), .gain_up());
   //////////////////////////////////////////
   task stop_test;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test
   // one apb transfer; a read notes {pslverr, prdata} expected in d
   task apb(input logic w, input logic [7:0] a, input logic [32:0] d);
      int i;
      if (!w) q.push_back(d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d[31:0];
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i == 20) begin
         n_mismatch++;
         stop_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // one sample on both channels; the idle edge after it keeps valid from being set twice at once
   task hit(input logic [11:0] a, input logic [11:0] b);
      sa <= a;
      sb <= b;
      va <= 1'b1;
      vb <= 1'b1;
      @(posedge pclk);
      va <= 1'b0;
      vb <= 1'b0;
      @(posedge pclk);
   endtask : hit
   // read results are compared with the oldest note as they appear
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         e = q.pop_front();
         `CHK("apb read", e, {pslverr, prdata})
      end
   end
   //////////////////////////////////////////
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, AORD_CTRL_OFF, 33'h0);
      apb(0, AORD_HIGH_THR_OFF, 33'h7FF);
      apb(0, 8'h18, 33'h100000000);
      $display("reset test done");
      apb(1, AORD_HIGH_THR_OFF, 33'h0E4);
      apb(1, AORD_LOW_THR_OFF, 33'h040);
      apb(1, AORD_CTRL_OFF, 33'h1);
      // random samples below both thresholds must stay silent
      repeat (50) hit(12'($random(seed) % 64), 12'($random(seed) % 64));
      apb(0, AORD_FLAGS_OFF, 33'h0);
      // negated -228 meets the high mark, 64 meets the low mark, on shared thresholds
      hit(12'hF1C, 12'h040);
      apb(0, AORD_FLAGS_OFF, 33'h00B);
      $display("threshold test done");
      for (int k = 0; k < 4; k++) begin
         len = 8 << sels[k];
         single <= k[0];
         apb(1, AORD_CTRL_OFF, {28'h0, 3'(sels[k]), k[0], 1'b1});
         apb(0, AORD_CTRL_OFF, {28'h0, 3'(sels[k]), k[0], 1'b1});
         hit(12'h800, 12'h000);
         repeat (len - 5) @(posedge pclk);
         `CHK("gain down", 1'b1, gdown)
         apb(0, AORD_FLAGS_OFF, 33'h003);
         repeat (2) @(posedge pclk);
         apb(0, AORD_FLAGS_OFF, 33'h000);
      end
      $display("pulse test done");
      apb(0, AORD_INT_STATUS_OFF, 33'h00B);
      `CHK("irq masked", 1'b0, irq)
      apb(1, AORD_INT_MASK_OFF, 33'h008);
      @(posedge pclk);
      `CHK("irq raised", 1'b1, irq)
      apb(1, AORD_INT_STATUS_OFF, 33'h008);
      @(posedge pclk);
      `CHK("irq cleared", 1'b0, irq)
      apb(0, AORD_INT_STATUS_OFF, 33'h003);
      $display("interrupt test done");
      stop_test();
   end
endmodule : tb_top
